// ---- inc/scsev_pkg.sv ----
// package: register map, field layouts and carriers of the sync event regs
package scsev_pkg;

    // register offsets on the plain register port (byte addresses)
    localparam logic [7:0] MODE_OFS    = 8'h00;
    localparam logic [7:0] EVENT_OFS   = 8'h02;
    localparam logic [7:0] MASK_OFS    = 8'h04;
    localparam logic [7:0] BD_IDX_OFS  = 8'h06;

    // values after reset
    localparam logic [15:0] MODE_RST   = 16'h0000;
    localparam logic [7:0]  EVENT_RST  = 8'h00;
    localparam logic [7:0]  MASK_RST   = 8'h00;

    // field positions
    localparam int MODE_PROTO_MSB      = 15;
    localparam int MODE_PROTO_LSB      = 6;
    localparam int EVENT_RSVD_BIT      = 5;
    localparam logic [7:0] EVENT_WMASK = 8'hdf;
    // bits that transparent mode defines (protocol 14..12, common 5..0)
    localparam logic [15:0] TRN_DEFINED = 16'h703f;
    // common field: bit 0 selects transparent framing
    localparam int COMMON_TRN_BIT      = 0;

    // default descriptor table depth
    localparam int BD_TABLE_DEPTH      = 8;

    // 16-bit mode register in character-synchronous layout
    typedef struct packed {
        logic       parity_mode;
        logic       external_sync_select;
        logic       no_transmit_sync;
        logic       reverse_data_order;
        logic       block_check_select;
        logic       rsvd10;
        logic       retransmit_enable;
        logic       receive_block_check_enable;
        logic       sync_frame_select;
        logic       line_coding_select;
        logic [5:0] common;
    } scsev_mode_t;

    // 8-bit event layout shared by event and mask registers
    typedef struct packed {
        logic clear_to_send;
        logic carrier_detect;
        logic rsvd5;
        logic transmit_error_event;
        logic receive_character_event;
        logic receive_busy_event;
        logic transmit;
        logic receive;
    } scsev_event_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } scsev_req_t;

endpackage

// ---- src/scsev_regs.sv ----
// serial channel sync/transparent mode, event, mask and interrupt registers
`timescale 1ns/1ps
// What this block does
// - the mode register is 16 bits, bits 15..6 protocol fields, 5..0 common.
// - sync layout: parity 15, ext sync 14, no tx sync 13, reverse 12, bcs 11, 10 reserved, retransmit 9, rx bcs 8, sync frame 7, coding 6.
// - the whole mode register clears to zero on reset.
// - a recognised sync event sets its bit of the 8-bit event register.
// - writing a one clears an event bit, several at once allowed.
// - the interrupt request stays high until every unmasked event is cleared.
// - the 8-bit mask register is read-write with the event layout, one enables.
// - the mask register clears to zero on reset.
// - transparent mode defines only bits 14, 13 and 12 of the protocol field.
// - the transparent view of the mode register clears to zero on reset.
// - transparent events set bits in the same 8-bit layout.
// - in transparent mode a one clears an event bit, a zero leaves it.
// - in transparent mode a mask one enables and a zero masks the event.
// - buffers come through descriptor tables; the device walks them.
module scsev_regs #(
    parameter int BD_DEPTH = scsev_pkg::BD_TABLE_DEPTH
) (
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    // register port
    input  wire scsev_pkg::scsev_req_t reg_req_in,
    output      logic [15:0]          reg_rdata_out,
    // events from the channel logic, one-cycle pulses
    input  wire scsev_pkg::scsev_event_t chan_event_in,
    // descriptor table progress from the channel logic
    input  wire logic                 tx_buf_done_in,
    input  wire logic                 rx_buf_done_in,
    // configuration towards the channel
    output      scsev_pkg::scsev_mode_t mode_out,
    output      logic                 transparent_out,
    output      logic [7:0]           tx_bd_index_out,
    output      logic [7:0]           rx_bd_index_out,
    // interrupt to the comms processor
    output      logic                 irq_out
);

    localparam logic [7:0] BD_LAST = 8'(BD_DEPTH - 1);

    scsev_pkg::scsev_mode_t  mode_q;
    scsev_pkg::scsev_event_t event_q;
    scsev_pkg::scsev_event_t event_d;
    scsev_pkg::scsev_event_t mask_q;
    logic [15:0]             rdata_q;
    logic                    irq_q;
    logic [7:0]              tx_idx_q;
    logic [7:0]              rx_idx_q;
    logic [15:0]             mode_wr_val;
    logic                    wr_mode;
    logic                    wr_event;
    logic                    wr_mask;
    logic                    wr_event_lo;
    logic [7:0]              ev_clear;
    logic [7:0]              ev_set;

    // address decode
    assign wr_mode  = reg_req_in.wr && reg_req_in.addr == scsev_pkg::MODE_OFS;
    assign wr_event = reg_req_in.wr && reg_req_in.addr == scsev_pkg::EVENT_OFS;
    assign wr_mask  = reg_req_in.wr && reg_req_in.addr == scsev_pkg::MASK_OFS;
    assign wr_event_lo = wr_event;

    // in transparent mode undefined protocol bits are kept as written;
    // software is expected to leave them at zero, nothing enforces it
    assign mode_wr_val = reg_req_in.wdata;

    // mode register: one word, two views by the common framing bit
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= scsev_pkg::MODE_RST;
        end else if (wr_mode) begin
            mode_q <= scsev_pkg::scsev_mode_t'(mode_wr_val);
        end
    end

    // event register: set beats clear so no event is lost
    always_comb begin
        ev_clear = wr_event_lo ? reg_req_in.wdata[7:0] : 8'h00;
        ev_set   = chan_event_in;
        event_d  = scsev_pkg::scsev_event_t'(
                   ((event_q & ~ev_clear) | ev_set)
                   & scsev_pkg::EVENT_WMASK);
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            event_q <= scsev_pkg::EVENT_RST;
        end else begin
            event_q <= event_d;
        end
    end

    // mask register
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask_q <= scsev_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_q <= scsev_pkg::scsev_event_t'(
                      reg_req_in.wdata[7:0] & scsev_pkg::EVENT_WMASK);
        end
    end

    // interrupt: recomputed each cycle from the stored flags, so it lags
    // an event pulse or a clear write by two cycles but never glitches on the output
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(event_q & mask_q);
        end
    end

    // descriptor table walk: each finished buffer moves to the next entry,
    // wrapping at the end of the table
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_idx_q <= 8'h00;
        end else if (tx_buf_done_in) begin
            tx_idx_q <= (tx_idx_q == BD_LAST) ? 8'h00 : tx_idx_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_idx_q <= 8'h00;
        end else if (rx_buf_done_in) begin
            rx_idx_q <= (rx_idx_q == BD_LAST) ? 8'h00 : rx_idx_q + 8'h01;
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                scsev_pkg::MODE_OFS:   rdata_q <= mode_q;
                scsev_pkg::EVENT_OFS:  rdata_q <= {8'h00, event_q};
                scsev_pkg::MASK_OFS:   rdata_q <= {8'h00, mask_q};
                scsev_pkg::BD_IDX_OFS: rdata_q <= {rx_idx_q, tx_idx_q};
                default:               rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata_out   = rdata_q;
    assign mode_out        = mode_q;
    assign transparent_out = mode_q.common[scsev_pkg::COMMON_TRN_BIT];
    assign tx_bd_index_out = tx_idx_q;
    assign rx_bd_index_out = rx_idx_q;
    assign irq_out         = irq_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_event_pulse(int b);
        chan_event_in[b] && b != scsev_pkg::EVENT_RSVD_BIT;
    endsequence

    sequence s_flag_then_irq;
        (|(event_q & mask_q)) ##1 irq_q;
    endsequence

    sequence s_rd_then_data;
        reg_req_in.rd && reg_req_in.addr == scsev_pkg::MODE_OFS
        ##1 reg_rdata_out == $past(mode_q);
    endsequence

    // multi-step behaviours checked below
    sequence s_mode_wr_gap_rd;
        wr_mode ##1 !wr_mode
        ##1 (reg_req_in.rd && reg_req_in.addr == scsev_pkg::MODE_OFS);
    endsequence

    sequence s_last_clear;
        irq_q && wr_event && chan_event_in == 8'h00
        && (event_q & mask_q & ~reg_req_in.wdata[7:0]) == 8'h00;
    endsequence

    sequence s_unmasked_event;
        (|(chan_event_in & mask_q)) && !wr_mask;
    endsequence

    sequence s_idx_rd;
        reg_req_in.rd && reg_req_in.addr == scsev_pkg::BD_IDX_OFS;
    endsequence

    // mode register
    a_mode_write: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_mode |=> mode_q == $past(reg_req_in.wdata))
        else $error("mode register did not take the written word");

    a_mode_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !wr_mode |=> $stable(mode_q))
        else $error("mode register changed without a write");

    a_mode_rdback: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_mode_wr_gap_rd |=> reg_rdata_out == $past(reg_req_in.wdata, 3))
        else $error("mode word read back differs from the write");

    a_reset_clear: assert property (
        @(posedge sys_clk_in)
        $fell(rst_in) |-> mode_q == 16'h0000 && mask_q == 8'h00
                          && event_q == 8'h00 && !irq_q)
        else $error("registers not clear after reset");

    // event flags
    a_set_wins: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        chan_event_in.receive |=> event_q.receive)
        else $error("receive event lost");

    a_set_over_clr: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        chan_event_in.transmit_error_event && wr_event
        && reg_req_in.wdata[4] |=> event_q.transmit_error_event)
        else $error("clear beat a simultaneous event");

    a_w1c_clear: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_event && chan_event_in == 8'h00
        |=> event_q == ($past(event_q) & ~$past(reg_req_in.wdata[7:0])
                        & scsev_pkg::EVENT_WMASK))
        else $error("write-one-to-clear misbehaved");

    a_clr_multi: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_event && chan_event_in == 8'h00 && $countones(event_q) > 1
        && (event_q & ~reg_req_in.wdata[7:0]) == 8'h00
        |=> event_q == 8'h00)
        else $error("one write failed to clear several flags");

    a_zero_keeps: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !wr_event && chan_event_in == 8'h00 |=> $stable(event_q))
        else $error("event flags moved with no cause");

    a_trn_event: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        transparent_out && chan_event_in.transmit_error_event
        |=> event_q.transmit_error_event)
        else $error("transparent event not recorded");

    a_trn_clear: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        transparent_out && wr_event && reg_req_in.wdata[4]
        && !chan_event_in.transmit_error_event
        |=> !event_q.transmit_error_event)
        else $error("transparent flag survived its clear");

    a_rsvd_zero: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !event_q[scsev_pkg::EVENT_RSVD_BIT]
        && !mask_q[scsev_pkg::EVENT_RSVD_BIT])
        else $error("reserved event bit became set");

    // one pass per live event position; the reserved one never latches
    for (genvar gi = 0; gi < 8; gi++) begin : g_ev_chk
        if (gi != scsev_pkg::EVENT_RSVD_BIT) begin : g_live
            a_bit_set: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                s_event_pulse(gi) |=> event_q[gi])
                else $error("event pulse did not set its flag");

            a_bit_clear: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                wr_event && reg_req_in.wdata[gi] && !chan_event_in[gi]
                |=> !event_q[gi])
                else $error("written one did not clear its flag");

            a_bit_keep: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                event_q[gi] && !chan_event_in[gi]
                && !(wr_event && reg_req_in.wdata[gi]) |=> event_q[gi])
                else $error("flag lost without a written one");

            a_bit_irq: assert property (
                @(posedge sys_clk_in) disable iff (rst_in)
                event_q[gi] && mask_q[gi] |=> irq_q)
                else $error("unmasked flag did not request");
        end
    end

    // interrupt request
    a_irq_raise: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_flag_then_irq or !(|(event_q & mask_q)))
        else $error("interrupt not raised for an unmasked event");

    a_irq_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        irq_q && (|(event_q & mask_q)) |=> irq_q)
        else $error("interrupt dropped while a flag is pending");

    a_irq_masked: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (event_q & mask_q) == 8'h00 |=> !irq_q)
        else $error("interrupt raised for masked events");

    a_trn_mask: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        transparent_out && (event_q & mask_q) == 8'h00 |=> !irq_q)
        else $error("transparent mask let an interrupt through");

    a_event_irq: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_unmasked_event |-> ##2 irq_q)
        else $error("unmasked event did not raise the interrupt");

    a_irq_release: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_last_clear |-> ##2 !irq_q)
        else $error("interrupt stayed after the last clear");

    // mask register
    a_mask_write: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_mask |=> mask_q == ($past(reg_req_in.wdata[7:0])
                               & scsev_pkg::EVENT_WMASK))
        else $error("mask register did not take the write");

    a_mask_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !wr_mask |=> $stable(mask_q))
        else $error("mask register changed without a write");

    // register port answers
    a_rd_mode: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        reg_req_in.rd && reg_req_in.addr == scsev_pkg::MODE_OFS
        |-> s_rd_then_data)
        else $error("mode read returned wrong data");

    a_rd_event: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        reg_req_in.rd && reg_req_in.addr == scsev_pkg::EVENT_OFS
        |=> reg_rdata_out == {8'h00, $past(event_q)})
        else $error("event read returned wrong data");

    a_rd_mask: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        reg_req_in.rd && reg_req_in.addr == scsev_pkg::MASK_OFS
        |=> reg_rdata_out == {8'h00, $past(mask_q)})
        else $error("mask read returned wrong data");

    a_rd_bd: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        s_idx_rd |=> reg_rdata_out == {$past(rx_idx_q), $past(tx_idx_q)})
        else $error("descriptor index read returned wrong data");

    // descriptor walk
    a_bd_walk: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        tx_buf_done_in |=> tx_idx_q == (($past(tx_idx_q) == BD_LAST)
                            ? 8'h00 : $past(tx_idx_q) + 8'h01))
        else $error("transmit descriptor index did not advance");

    a_rx_walk: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        rx_buf_done_in |=> rx_idx_q == (($past(rx_idx_q) == BD_LAST)
                            ? 8'h00 : $past(rx_idx_q) + 8'h01))
        else $error("receive descriptor index did not advance");

    a_bd_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !tx_buf_done_in && !rx_buf_done_in
        |=> $stable(tx_idx_q) && $stable(rx_idx_q))
        else $error("descriptor index moved with no finished buffer");

    a_bd_range: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        tx_idx_q <= BD_LAST && rx_idx_q <= BD_LAST)
        else $error("descriptor index ran past the table end");

endmodule

// ---- dv/scsev_chan_model.sv ----
// channel-side partner model: event pulses and buffer completions
`timescale 1ns/1ps
module scsev_chan_model (
    // clock
    input  wire logic              clk_in,
    // towards the register block
    output      scsev_pkg::scsev_event_t event_out,
    output      logic              tx_done_out,
    output      logic              rx_done_out
);
    initial begin
        event_out = '0;
        tx_done_out = 1'b0;
        rx_done_out = 1'b0;
    end
    // events are one-cycle pulses, never levels, so a missed edge shows
    task automatic raise(input logic [7:0] ev);
        @(posedge clk_in);
        event_out <= scsev_pkg::scsev_event_t'(ev);
        @(posedge clk_in);
        event_out <= '0;
    endtask
    // a closed buffer moves the descriptor walk on by one entry
    task automatic buf_done(input logic tx, input logic rx);
        @(posedge clk_in);
        tx_done_out <= tx;
        rx_done_out <= rx;
        @(posedge clk_in);
        tx_done_out <= 1'b0;
        rx_done_out <= 1'b0;
    endtask
endmodule

// ---- dv/scsev_regs_test.sv ----
// self-checking bench of the sync event register block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("[ERR] %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module scsev_regs_test;
    // small table depth so the wrap is reached quickly
    localparam int DEPTH = 4;
    logic                    sys_clk_in = 1'b0;
    logic                    rst_in = 1'b1;
    scsev_pkg::scsev_req_t   req = '0;
    logic [15:0]             rdata;
    scsev_pkg::scsev_event_t ev;
    scsev_pkg::scsev_mode_t  mode;
    logic                    transp;
    logic                    tx_done;
    logic                    rx_done;
    logic                    irq;
    logic [7:0]              tx_idx;
    logic [7:0]              rx_idx;
    int                      err_count = 0;
    int                      check_count = 0;
    always #25 sys_clk_in = ~sys_clk_in;
    scsev_regs #(.BD_DEPTH(DEPTH)) uut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .chan_event_in(ev),
        .tx_buf_done_in(tx_done), .rx_buf_done_in(rx_done),
        .mode_out(mode), .transparent_out(transp),
        .tx_bd_index_out(tx_idx), .rx_bd_index_out(rx_idx), .irq_out(irq));
    scsev_chan_model chan (
        .clk_in(sys_clk_in), .event_out(ev),
        .tx_done_out(tx_done), .rx_done_out(rx_done));
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask
    // data is registered at the edge that takes rd, so sample just after it
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk_in);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    // irq follows its cause by two edges, a fixed lag
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge sys_clk_in);
        #1;
        `CHK(irq, e)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd_chk(scsev_pkg::MODE_OFS, 16'h0000);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0000);
        rd_chk(scsev_pkg::MASK_OFS, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            wr(scsev_pkg::MODE_OFS, 16'h0001 << i);
            rd_chk(scsev_pkg::MODE_OFS, 16'h0001 << i);
        end
        wr(scsev_pkg::MODE_OFS, 16'h8040);
        #1;
        `CHK({mode.parity_mode, mode.line_coding_select}, 2'h3)
        `CHK({mode.block_check_select, transp}, 2'h0)
        $display("test mode fields done");
        wr(scsev_pkg::MODE_OFS, 16'h0000);
        wr(scsev_pkg::MASK_OFS, 16'hffff);
        rd_chk(scsev_pkg::MASK_OFS, 16'h00df);
        wr(scsev_pkg::MASK_OFS, 16'h0000);
        chan.raise(8'hff);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h00df);
        irq_chk(1'b0);
        wr(scsev_pkg::MASK_OFS, 16'h0003);
        irq_chk(1'b1);
        wr(scsev_pkg::EVENT_OFS, 16'hff02);
        irq_chk(1'b1);
        wr(scsev_pkg::EVENT_OFS, 16'h0001);
        irq_chk(1'b0);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h00dc);
        wr(scsev_pkg::EVENT_OFS, 16'h00dc);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0000);
        // every position alone: the request is an or over the seven live ones, bit 5 never requests
        for (int i = 0; i < 8; i++) begin
            wr(scsev_pkg::MASK_OFS, 16'h0001 << i);
            chan.raise(8'h01 << i);
            irq_chk(i != 5);
            wr(scsev_pkg::EVENT_OFS, 16'h00ff);
            irq_chk(1'b0);
        end
        $display("test sync events done");
        wr(scsev_pkg::MODE_OFS, 16'h7001);
        #1;
        `CHK({mode.external_sync_select, mode.no_transmit_sync}, 2'h3)
        `CHK({mode.reverse_data_order, transp}, 2'h3)
        `CHK(mode, 16'h7001)
        wr(scsev_pkg::MASK_OFS, 16'h0010);
        chan.raise(8'h10);
        irq_chk(1'b1);
        wr(scsev_pkg::EVENT_OFS, 16'h00ef);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0010);
        wr(scsev_pkg::MASK_OFS, 16'h0000);
        irq_chk(1'b0);
        wr(scsev_pkg::EVENT_OFS, 16'h0010);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0000);
        // an event landing with its own clear must survive the clear
        chan.raise(8'h10);
        fork
            chan.raise(8'h10);
            wr(scsev_pkg::EVENT_OFS, 16'h0010);
        join
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0010);
        wr(scsev_pkg::EVENT_OFS, 16'h0010);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0000);
        $display("test transparent done");
        wr(8'h08, 16'hffff);
        rd_chk(8'h08, 16'h0000);
        repeat (DEPTH + 1) chan.buf_done(1'b1, 1'b0);
        repeat (2) chan.buf_done(1'b0, 1'b1);
        wr(scsev_pkg::BD_IDX_OFS, 16'hffff);
        rd_chk(scsev_pkg::BD_IDX_OFS, 16'h0201);
        `CHK({rx_idx, tx_idx}, 16'h0201)
        $display("test descriptors done");
        wr(scsev_pkg::MASK_OFS, 16'h000f);
        chan.raise(8'h01);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1;
        `CHK(irq, 1'b0)
        rd_chk(scsev_pkg::MODE_OFS, 16'h0000);
        rd_chk(scsev_pkg::MASK_OFS, 16'h0000);
        rd_chk(scsev_pkg::EVENT_OFS, 16'h0000);
        $display("test second reset done");
        summarize();
    end
endmodule
